// file: core/sleep_wake_pkg.sv
// shared constants and types for the sleep and wake controller
package sleep_wake_pkg;

  // register byte offsets on the wishbone bus
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h4;
  localparam logic [3:0] ADDR_IRQ_STS = 4'h8;
  localparam logic [3:0] ADDR_IRQ_MSK = 4'hC;

  // status register bit positions
  localparam int STS_POWERDOWN_BIT = 3;
  localparam int STS_TIMEOUT_BIT   = 4;
  localparam int STS_ASLEEP_BIT    = 0;
  // configuration word watchdog enable position
  localparam int CFG_WDT_EN_BIT    = 2;

  // control register bit positions
  localparam int CTRL_SLEEP_BIT    = 0;
  localparam int CTRL_WDT_CLR_BIT  = 1;

  // interrupt event bit positions
  localparam int EV_SLEEP_BIT      = 0;
  localparam int EV_WAKE_PIN_BIT   = 1;
  localparam int EV_WAKE_WDT_BIT   = 2;
  localparam int EV_WDT_RUN_BIT    = 3;
  localparam int EV_WIDTH          = 4;

  // reset values
  localparam logic [EV_WIDTH-1:0] IRQ_MSK_RST = 4'h0;
  localparam logic [15:0] WDT_LIMIT_RST = 16'hFFFF;
  // full-reset pulse length in cycles
  localparam int RESET_PULSE_CYC = 4;

  typedef enum logic [1:0] {
    ST_RUN,
    ST_SLEEP,
    ST_WAKE
  } power_state_t;

  typedef struct packed {
    logic timeout_flag_n;
    logic powerdown_flag_n;
  } cause_flags_t;

endpackage

// file: core/sleep_wake_control.sv
// power-down entry, wake-up and reset-cause flags for the core
`timescale 1ns/1ps
`default_nettype none

// Contract
// RQ1 - only sleep instruction enters power-down
// RQ2 - enabled watchdog cleared, keeps counting asleep
// RQ3 - entering power-down sets timeout flag
// RQ4 - entering power-down clears powerdown flag
// RQ5 - oscillator driver off during power-down
// RQ6 - I/O pins hold pre-sleep state
// RQ7 - watchdog reset never drives clear pin
// RQ8 - wake only by clear pin or watchdog
// RQ9 - every wake gives full device reset
// RQ10 - watchdog time-out clears timeout flag
// RQ11 - power-up sets powerdown flag high
// RQ12 - watchdog cleared on every wake-up
// RQ13 - outside holds timer clock, clear pin high
// RQ14 - config bit two enables watchdog
// RQ15 - no execution, flags held while asleep
module sleep_wake_control
  import sleep_wake_pkg::*;
#(
  parameter int IO_WIDTH  = 12,
  parameter int WDT_WIDTH = 16
) (
  // clock and power-on reset
  input  wire logic                 clk,
  input  wire logic                 rst,
  // wishbone slave
  input  wire logic                 wb_cyc_i,
  input  wire logic                 wb_stb_i,
  input  wire logic                 wb_we_i,
  input  wire logic [3:0]           wb_adr_i,
  input  wire logic [3:0]           wb_sel_i,
  input  wire logic [31:0]          wb_dat_i,
  output var  logic [31:0]          wb_dat_o,
  output var  logic                 wb_ack_o,
  // core side
  input  wire logic                 sleep_exec,
  input  wire logic                 wdt_clear_exec,
  input  wire logic [11:0]          config_word,
  output var  logic                 core_run,
  output var  logic                 core_reset,
  output var  logic                 osc_drive_en,
  // pins
  input  wire logic                 master_clear_n_pin,
  input  wire logic [IO_WIDTH-1:0]  io_out_core,
  input  wire logic [IO_WIDTH-1:0]  io_oe_core,
  output var  logic [IO_WIDTH-1:0]  io_out,
  output var  logic [IO_WIDTH-1:0]  io_oe,
  output var  logic                 master_clear_out,
  output var  logic                 master_clear_oe,
  // flags and interrupt
  output var  cause_flags_t         cause_flags,
  output var  logic                 irq
);

  power_state_t          state;
  logic [1:0]            mclr_sync;
  logic                  mclr_low;
  logic [WDT_WIDTH-1:0]  wdt_count;
  logic [WDT_WIDTH-1:0]  wdt_limit;
  logic                  wdt_timeout;
  logic                  wdt_en;
  logic                  sw_sleep;
  logic                  sw_wdt_clr;
  logic                  enter_sleep;
  logic                  wake_pin;
  logic                  wake_wdt;
  logic [2:0]            rst_cnt;
  logic [EV_WIDTH-1:0]   irq_sts;
  logic [EV_WIDTH-1:0]   irq_msk;
  logic [EV_WIDTH-1:0]   ev;
  logic                  wb_req;
  logic                  wb_wr;
  logic [31:0]           next_rdata;
  power_state_t          next_state;
  logic                  next_core_reset;
  logic                  next_core_run;
  logic                  next_osc_drive_en;
  logic                  running;
  logic                  asleep;
  logic                  wake_any;
  logic                  rst_done;

  function automatic logic hit(input logic [3:0] a, input logic [3:0] off);
    return a == off;
  endfunction

  // reset pin crosses in from outside: two flops before use
  always_ff @(posedge clk) begin
    if (rst) begin
      mclr_sync <= 2'h3;
    end else begin
      mclr_sync <= {mclr_sync[0], master_clear_n_pin};
    end
  end
  assign mclr_low = ~mclr_sync[1];

  // RQ14 watchdog enable bit
  assign wdt_en = config_word[CFG_WDT_EN_BIT];
  assign wdt_timeout = wdt_en && (wdt_count >= wdt_limit);

  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];

  // shared state decodes
  assign running  = (state == ST_RUN);
  assign asleep   = (state == ST_SLEEP);
  assign rst_done = (rst_cnt == 3'(RESET_PULSE_CYC - 1));

  // RQ1 sleep only from instruction
  // a reset cause in the same cycle wins, so the core never sleeps in reset
  assign enter_sleep = running && !core_reset && !mclr_low &&
                       !wdt_timeout && (sleep_exec || sw_sleep);
  // RQ8 two wake sources only
  // the pin wins over a watchdog wake that lands in the same cycle
  assign wake_pin = asleep && mclr_low;
  assign wake_wdt = asleep && wdt_timeout && !mclr_low;
  assign wake_any = wake_pin || wake_wdt;

  // software sleep request stands for a sleep instruction of the core
  assign sw_sleep   = wb_wr && hit(wb_adr_i, ADDR_CTRL) &&
                      wb_dat_i[CTRL_SLEEP_BIT];
  assign sw_wdt_clr = wb_wr && hit(wb_adr_i, ADDR_CTRL) &&
                      wb_dat_i[CTRL_WDT_CLR_BIT];

  always_comb begin
    next_state = state;
    unique case (state)
      ST_RUN: begin
        if (enter_sleep) begin
          next_state = ST_SLEEP;
        end
      end
      // RQ9 wake goes through reset
      ST_SLEEP: begin
        if (wake_any) begin
          next_state = ST_WAKE;
        end
      end
      ST_WAKE: begin
        // the core restarts only once the pin is released
        if (rst_done && !mclr_low) begin
          next_state = ST_RUN;
        end
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ST_RUN;
    end else begin
      state <= next_state;
    end
  end

  // reset pulse length counter, counts up in ST_WAKE and holds at RESET_PULSE_CYC - 1 whatever the pin does
  always_ff @(posedge clk) begin
    if (rst || state != ST_WAKE) begin
      rst_cnt <= 3'h0;
    end else if (!rst_done) begin
      rst_cnt <= rst_cnt + 3'h1;
    end
  end

  // RQ9 full reset pulse; a wake never resumes after the sleep
  always_comb begin
    next_core_reset = 1'b0;
    unique case (state)
      ST_RUN: begin
        // pin or watchdog reset while running, no sleep involved
        next_core_reset = mclr_low || wdt_timeout;
      end
      ST_SLEEP: begin
        next_core_reset = wake_any;
      end
      ST_WAKE: begin
        // stretched while the pin stays low
        next_core_reset = !rst_done || mclr_low;
      end
    endcase
  end

  // RQ15 no fetch while asleep or in reset
  always_comb begin
    next_core_run = 1'b0;
    if (running) begin
      next_core_run = !enter_sleep && !mclr_low && !wdt_timeout &&
                      !core_reset;
    end
  end

  // RQ5 oscillator driver off from entry until a wake event
  always_comb begin
    next_osc_drive_en = 1'b1;
    if (running && enter_sleep) begin
      next_osc_drive_en = 1'b0;
    end else if (asleep && !wake_any) begin
      next_osc_drive_en = 1'b0;
    end
  end

  // core-side outputs come straight from flops
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reset   <= 1'b1;
      core_run     <= 1'b0;
      osc_drive_en <= 1'b1;
    end else begin
      core_reset   <= next_core_reset;
      core_run     <= next_core_run;
      osc_drive_en <= next_osc_drive_en;
    end
  end

  // RQ2 cleared on entry, keeps running
  // RQ12 cleared on every wake
  always_ff @(posedge clk) begin
    if (rst || !wdt_en) begin
      wdt_count <= '0;
    end else if (enter_sleep || wake_pin || wake_wdt || wdt_timeout ||
                 wdt_clear_exec || sw_wdt_clr || state == ST_WAKE) begin
      wdt_count <= '0;
    end else begin
      wdt_count <= wdt_count + WDT_WIDTH'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_limit <= WDT_WIDTH'(WDT_LIMIT_RST);
    end else if (wb_wr && hit(wb_adr_i, ADDR_CTRL) &&
                 wb_dat_i[31:16] != 16'h0000) begin
      // a zero limit would time out at once, so it keeps the old one
      wdt_limit <= WDT_WIDTH'(wb_dat_i[31:16]);
    end
  end

  // RQ11 power-up sets both flags
  always_ff @(posedge clk) begin
    if (rst) begin
      cause_flags <= '{timeout_flag_n: 1'b1, powerdown_flag_n: 1'b1};
    end else if (wdt_timeout) begin
      // RQ10 time-out clears timeout flag
      cause_flags.timeout_flag_n <= 1'b0;
    end else if (enter_sleep) begin
      // RQ3 set timeout flag
      cause_flags.timeout_flag_n <= 1'b1;
      // RQ4 clear powerdown flag
      cause_flags.powerdown_flag_n <= 1'b0;
    end
  end

  // RQ6 pins frozen while asleep
  always_ff @(posedge clk) begin
    if (rst) begin
      io_out <= '0;
      io_oe  <= '0;
    end else if (state == ST_RUN && !enter_sleep) begin
      io_out <= io_out_core;
      io_oe  <= io_oe_core;
    end
  end

  // RQ7 watchdog reset stays internal
  always_ff @(posedge clk) begin
    master_clear_out <= 1'b1;
    master_clear_oe  <= 1'b0;
  end

  assign ev[EV_SLEEP_BIT]    = enter_sleep;
  assign ev[EV_WAKE_PIN_BIT] = wake_pin;
  assign ev[EV_WAKE_WDT_BIT] = wake_wdt;
  assign ev[EV_WDT_RUN_BIT]  = wdt_timeout && state == ST_RUN;

  // events win over a write-one clear in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_sts <= '0;
    end else if (wb_wr && hit(wb_adr_i, ADDR_IRQ_STS)) begin
      irq_sts <= (irq_sts & ~wb_dat_i[EV_WIDTH-1:0]) | ev;
    end else begin
      irq_sts <= irq_sts | ev;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq_msk <= IRQ_MSK_RST;
    end else if (wb_wr && hit(wb_adr_i, ADDR_IRQ_MSK)) begin
      irq_msk <= wb_dat_i[EV_WIDTH-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_sts & irq_msk);
    end
  end

  always_comb begin
    next_rdata = 32'h0000_0000;
    unique case (wb_adr_i)
      ADDR_CTRL:    next_rdata = {16'(wdt_limit), 16'h0000};
      ADDR_STATUS: begin
        next_rdata[STS_TIMEOUT_BIT]   = cause_flags.timeout_flag_n;
        next_rdata[STS_POWERDOWN_BIT] = cause_flags.powerdown_flag_n;
        next_rdata[STS_ASLEEP_BIT]    = (state == ST_SLEEP);
      end
      ADDR_IRQ_STS: next_rdata[EV_WIDTH-1:0] = irq_sts;
      ADDR_IRQ_MSK: next_rdata[EV_WIDTH-1:0] = irq_msk;
      default:      next_rdata = 32'h0000_0000;
    endcase
  end

  // one wait-free ack per request; unmapped reads return zero
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req) begin
        wb_dat_o <= next_rdata;
      end
    end
  end

endmodule

`default_nettype wire

// file: sim/sleep_wake_assertions.sv
// concurrent checks on the sleep and wake controller ports
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_assertions
  import sleep_wake_pkg::*;
#(
  parameter int IO_WIDTH = 12
) (
  // clock and reset
  input wire logic                clk,
  input wire logic                rst,
  // bus and core
  input wire logic                wb_cyc_i,
  input wire logic                wb_stb_i,
  input wire logic                wb_we_i,
  input wire logic                wb_ack_o,
  input wire logic                sleep_exec,
  input wire logic                core_run,
  input wire logic                core_reset,
  input wire logic                osc_drive_en,
  // pins and flags
  input wire logic                master_clear_n_pin,
  input wire logic [IO_WIDTH-1:0] io_out,
  input wire logic [IO_WIDTH-1:0] io_oe,
  input wire logic                master_clear_oe,
  input wire cause_flags_t        cause_flags
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_asleep2;
    !osc_drive_en ##1 !osc_drive_en;
  endsequence
  sequence s_reset_held;
    core_reset [*4];
  endsequence
  a_sleep_entry: assert property (
    sleep_exec && core_run |=> !core_run && !osc_drive_en
    && cause_flags == 2'b10) else $error("sleep entry outputs wrong");
  a_only_sleep: assert property (
    $fell(osc_drive_en) |-> $past(sleep_exec)
    || $past(wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o))
    else $error("power-down without sleep");
  a_osc_off: assert property (
    !osc_drive_en |-> !core_run && !core_reset)
    else $error("core active while asleep");
  a_io_frozen: assert property (
    s_asleep2 |-> $stable(io_out) && $stable(io_oe))
    else $error("pins moved while asleep");
  a_flags_hold: assert property (
    s_asleep2 |-> $stable(cause_flags)) else $error("flags moved asleep");
  a_pin_undriven: assert property (
    !master_clear_oe) else $error("clear pin driven");
  a_wake_reset: assert property (
    $rose(osc_drive_en) |-> s_reset_held) else $error("wake reset short");
  a_pin_wake: assert property (
    !osc_drive_en && !master_clear_n_pin |-> ##[1:4] osc_drive_en)
    else $error("pin did not wake");
  a_ack_once: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus ack not one pulse");
endmodule
bind sleep_wake_control sleep_wake_assertions #(.IO_WIDTH(IO_WIDTH))
  sleep_wake_assertions_inst (.*);
`default_nettype wire

// file: sim/ext_reset_source.sv
// external reset source driving the clear pin
`timescale 1ns/1ps
`default_nettype none
module ext_reset_source (
  // clock and request
  input  wire logic       clk,
  input  wire logic       press,
  input  wire logic [3:0] hold,
  // pin
  output var  logic       master_clear_n_pin
);
  initial master_clear_n_pin = 1'b1;
  always @(posedge clk) begin
    if (press) begin
      master_clear_n_pin <= 1'b0;
      repeat (hold) @(posedge clk);
      master_clear_n_pin <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// file: sim/sleep_wake_control_bench.sv
// self-checking bench for the sleep and wake controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wake_control_bench;
  import sleep_wake_pkg::*;
  logic         clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq;
  logic [3:0]   wb_adr_i, wb_sel_i, hold;
  logic [31:0]  wb_dat_i, wb_dat_o, rd;
  logic         sleep_exec, wdt_clear_exec, core_run, core_reset;
  logic         osc_drive_en, master_clear_out, master_clear_oe, press;
  logic         master_clear_n_pin;
  logic [11:0]  config_word, io_out_core, io_oe_core, io_out, io_oe;
  cause_flags_t cause_flags;
  logic [1:0]   exp_flags;
  int           failures, checks, seed, n;
  sleep_wake_control sleep_wake_control_inst (.*);
  ext_reset_source ext_reset_source_inst (.clk(clk), .press(press),
    .hold(hold), .master_clear_n_pin(master_clear_n_pin));
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    checks++;
    if (seen !== want) begin
      failures++;
      $display("FAIL %0t seen %h want %h", $time, seen, want);
    end
  endtask
  task automatic end_of_test;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wb(input logic we, input logic [3:0] a,
                    input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk);
      k++;
    end while (wb_ack_o !== 1'b1 && k < 20);
    if (wb_ack_o !== 1'b1) begin
      failures++;
      end_of_test();
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_run(input int lim);
    n = 0;
    while (core_run !== 1'b1 && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (n >= lim) begin
      failures++;
      end_of_test();
    end
  endtask
  task automatic do_sleep;
    logic [11:0] v;
    v = 12'($random(seed));
    io_out_core <= v;
    io_oe_core <= ~v;
    @(posedge clk);
    sleep_exec <= 1'b1;
    @(posedge clk);
    sleep_exec <= 1'b0;
    // the core keeps changing its drive; the pins must not follow
    io_out_core <= 12'($random(seed));
    exp_flags = 2'b10;
    @(posedge clk);
    check(cause_flags, exp_flags);
    check(osc_drive_en, 1'b0);
    check(io_out, v);
    check(io_oe, 12'(~v));
  endtask
  task automatic pin_wake(input logic [3:0] h);
    hold <= h;
    press <= 1'b1;
    @(posedge clk);
    press <= 1'b0;
    wait_run(100);
    check(cause_flags, exp_flags);
  endtask
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial begin
    {failures, checks, n} = '0;
    seed = 42;
    {wb_cyc_i, wb_stb_i, wb_we_i, sleep_exec, wdt_clear_exec} = '0;
    {wb_adr_i, wb_dat_i, io_out_core, io_oe_core, press} = '0;
    {rst, wb_sel_i, hold, config_word} = {1'b1, 4'hF, 4'h3, 12'h004};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    exp_flags = 2'b11;
    check(cause_flags, exp_flags);
    wb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h18);
    wb(1'b0, 4'h2, 32'h0);
    check(rd, 32'h0);
    wb(1'b1, ADDR_IRQ_MSK, 32'h1);
    do_sleep();
    @(posedge clk);
    check(irq, 1'b1);
    wb(1'b1, ADDR_IRQ_MSK, 32'h0);
    @(posedge clk);
    check(irq, 1'b0);
    wb(1'b1, ADDR_IRQ_STS, 32'h1);
    wb(1'b1, ADDR_IRQ_MSK, 32'h1);
    @(posedge clk);
    check(irq, 1'b0);
    pin_wake(4'h3);
    wb(1'b1, ADDR_CTRL, 32'h0040_0002);
    do_sleep();
    wait_run(400);
    exp_flags = 2'b00;
    check(cause_flags, exp_flags);
    check(n > 50, 1'b1);
    config_word <= 12'h000;
    wb(1'b1, ADDR_CTRL, 32'h0040_0002);
    do_sleep();
    repeat (150) @(posedge clk);
    check(osc_drive_en, 1'b0);
    pin_wake(4'h9);
    check(master_clear_oe, 1'b0);
    check(master_clear_out, 1'b1);
    wb(1'b1, ADDR_CTRL, 32'h0000_0001);
    check(osc_drive_en, 1'b0);
    check(core_run, 1'b0);
    wb(1'b0, ADDR_STATUS, 32'h0);
    check(rd, 32'h11);
    end_of_test();
  end
endmodule
`default_nettype wire
